// file: design/fsr_pkg.sv
// constants for the factory signature row: geometry, word indices, populated map, field layout
// assumes byte addressing on the bus, one aligned word per signature byte
package fsr_pkg;

  // ****************************************
  // geometry
  // ****************************************
  localparam int             SIG_DEPTH = 48;
  localparam int             IDX_W     = 6;
  localparam int             ADDR_W    = 8;
  localparam int             SERIAL_W  = 88;
  localparam int             TEMP_W    = 12;

  // ****************************************
  // word indices (byte address = 4 * index)
  // ****************************************
  localparam logic [5:0] IDX_OSC2M_B   = 6'h00;
  localparam logic [5:0] IDX_OSC2M_A   = 6'h01;
  localparam logic [5:0] IDX_OSC32K    = 6'h02;
  localparam logic [5:0] IDX_OSC32M_B  = 6'h03;
  localparam logic [5:0] IDX_OSC32M_A  = 6'h04;
  localparam logic [5:0] IDX_LOT_0     = 6'h08;
  localparam logic [5:0] IDX_WAFER     = 6'h10;
  localparam logic [5:0] IDX_X_LOW     = 6'h12;
  localparam logic [5:0] IDX_X_HIGH    = 6'h13;
  localparam logic [5:0] IDX_Y_LOW     = 6'h14;
  localparam logic [5:0] IDX_Y_HIGH    = 6'h15;
  localparam logic [5:0] IDX_CONV_A_LO = 6'h20;
  localparam logic [5:0] IDX_CONV_A_HI = 6'h21;
  localparam logic [5:0] IDX_CONV_B_LO = 6'h24;
  localparam logic [5:0] IDX_CONV_B_HI = 6'h25;
  localparam logic [5:0] IDX_TEMP_LOW  = 6'h2E;
  localparam logic [5:0] IDX_TEMP_HIGH = 6'h2F;
  localparam logic [5:0] IDX_STATUS    = 6'h30;
  localparam int         LOT_BYTES     = 6;

  // one bit per populated signature index; others read zero
  localparam logic [47:0] SIG_MAP = 48'hC033_003D_3F1F;

  // ****************************************
  // fields
  // ****************************************
  localparam logic [7:0] TEMP_HIGH_MASK = 8'h0F;
  localparam logic [7:0] BYTE_MASK      = 8'hFF;
  localparam int         ST_LOADED_BIT  = 0;
  localparam int         ST_WRERR_BIT   = 1;

endpackage : fsr_pkg

// file: design/fsr_fuse_rom.sv
// factory fuse image of the signature row, masked to the populated bytes
// assumes the image is fixed at build time; nothing can change it at run time
`timescale 1ns/1ns
`default_nettype none
module fsr_fuse_rom
  import fsr_pkg::*;
#(
  parameter logic [8*SIG_DEPTH-1:0] IMAGE = '0
) (
  input  wire logic [IDX_W-1:0]       idx_in,
  output logic      [7:0]             rd_byte_out,
  output logic      [8*SIG_DEPTH-1:0] bytes_out
);

  // ****************************************
  // masking per entry
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < SIG_DEPTH; i++) begin : g_byte
      localparam logic [7:0] MASK = (i == int'(IDX_TEMP_HIGH)) ? TEMP_HIGH_MASK : BYTE_MASK;
      // upper nibble of the high temperature byte always reads zero
      assign bytes_out[i*8 +: 8] = SIG_MAP[i] ? (IMAGE[i*8 +: 8] & MASK) : 8'h00;
    end
  endgenerate

  // read-only by construction: no write path exists
  assign rd_byte_out = (int'(idx_in) < SIG_DEPTH) ? bytes_out[idx_in*8 +: 8] : 8'h00;

endmodule : fsr_fuse_rom
`default_nettype wire

// file: design/fsr_signature_row.sv
// factory signature row: read-only fuse bytes on an Avalon-MM slave,
// oscillator trim copied out while reset is held
// assumes rst_in is synchronous to clk_in and held for at least one edge
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module fsr_signature_row
  import fsr_pkg::*;
#(
  parameter logic [8*SIG_DEPTH-1:0] FACTORY_IMAGE = '0
) (
  input  wire logic                clk_in,
  input  wire logic                rst_in,
  input  wire logic [ADDR_W-1:0]   avs_address_in,
  input  wire logic                avs_read_in,
  input  wire logic                avs_write_in,
  input  wire logic [31:0]         avs_writedata_in,
  input  wire logic [3:0]          avs_byteenable_in,
  output logic      [31:0]         avs_readdata_out,
  output logic                     avs_waitrequest_out,
  output logic      [7:0]          fll2m_loop_trim_b_out,
  output logic      [7:0]          fll2m_loop_trim_a_out,
  output logic      [7:0]          slow_osc_trim_out,
  output logic      [7:0]          fll32m_loop_trim_b_out,
  output logic      [7:0]          fll32m_loop_trim_a_out,
  output logic      [SERIAL_W-1:0] serial_number_out,
  output logic      [TEMP_W-1:0]   temp_ref_out,
  output logic                     trim_loaded_out
);

  // ****************************************
  // fuse image
  // ****************************************
  logic [IDX_W-1:0]       idx;
  logic [7:0]             rom_byte;
  logic [8*SIG_DEPTH-1:0] sig;

  assign idx = avs_address_in[ADDR_W-1:2];

  fsr_fuse_rom #(
    .IMAGE (FACTORY_IMAGE)
  ) u_rom (
    .idx_in      (idx),
    .rd_byte_out (rom_byte),
    .bytes_out   (sig)
  );

  function automatic logic [7:0] sig_byte(input logic [5:0] k);
    sig_byte = sig[k*8 +: 8];
  endfunction : sig_byte

  // ****************************************
  // reset-time trim copy
  // ****************************************
  logic [7:0] trim_2m_b_r;
  logic [7:0] trim_2m_a_r;
  logic [7:0] trim_32k_r;
  logic [7:0] trim_32m_b_r;
  logic [7:0] trim_32m_a_r;
  logic       loaded_r;

  // the copy happens on every edge while reset is held, so one edge suffices
  // and a longer reset just repeats it; converter bytes have no path here
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      trim_2m_b_r  <= sig_byte(IDX_OSC2M_B);
      trim_2m_a_r  <= sig_byte(IDX_OSC2M_A);
      trim_32k_r   <= sig_byte(IDX_OSC32K);
      trim_32m_b_r <= sig_byte(IDX_OSC32M_B);
      trim_32m_a_r <= sig_byte(IDX_OSC32M_A);
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      loaded_r <= 1'b1;
    end
  end

  assign fll2m_loop_trim_b_out  = trim_2m_b_r;
  assign fll2m_loop_trim_a_out  = trim_2m_a_r;
  assign slow_osc_trim_out      = trim_32k_r;
  assign fll32m_loop_trim_b_out = trim_32m_b_r;
  assign fll32m_loop_trim_a_out = trim_32m_a_r;
  assign trim_loaded_out        = loaded_r;

  // ****************************************
  // serial number and temperature reference
  // ****************************************
  logic [SERIAL_W-1:0] serial_r;
  logic [TEMP_W-1:0]   temp_r;
  logic [SERIAL_W-1:0] serial_nxt;

  // lot bytes 0..5 low, then wafer index, X low/high, Y low/high
  always_comb begin
    serial_nxt = '0;
    for (int k = 0; k < LOT_BYTES; k++) begin
      serial_nxt[k*8 +: 8] = sig[(int'(IDX_LOT_0) + k)*8 +: 8];
    end
    serial_nxt[48 +: 8] = sig_byte(IDX_WAFER);
    serial_nxt[56 +: 8] = sig_byte(IDX_X_LOW);
    serial_nxt[64 +: 8] = sig_byte(IDX_X_HIGH);
    serial_nxt[72 +: 8] = sig_byte(IDX_Y_LOW);
    serial_nxt[80 +: 8] = sig_byte(IDX_Y_HIGH);
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      serial_r <= serial_nxt;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      temp_r <= {sig[int'(IDX_TEMP_HIGH)*8 +: 4], sig_byte(IDX_TEMP_LOW)};
    end
  end

  assign serial_number_out = serial_r;
  assign temp_ref_out      = temp_r;

  // ****************************************
  // Avalon-MM slave, one wait state
  // ****************************************
  logic        ack_r;
  logic [31:0] rdata_r;
  logic        wrerr_r;
  logic        req;
  logic        wr_done;
  logic        sig_hit;
  logic        stat_hit;
  logic        wrerr_clr;

  assign req      = avs_read_in | avs_write_in;
  assign sig_hit  = int'(idx) < SIG_DEPTH;
  assign stat_hit = idx == IDX_STATUS;
  assign wr_done  = avs_write_in & ack_r;

  // first cycle of a request always waits; the read data is registered then
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  assign avs_waitrequest_out = req & ~ack_r;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_r <= 32'h0000_0000;
    end else if (avs_read_in & ~ack_r) begin
      if (sig_hit) begin
        rdata_r <= {24'h00_0000, rom_byte};
      end else if (stat_hit) begin
        rdata_r <= {30'h0000_0000, wrerr_r, loaded_r};
      end else begin
        rdata_r <= 32'h0000_0000;
      end
    end
  end

  assign avs_readdata_out = rdata_r;

  // ****************************************
  // write-attempt flag
  // ****************************************
  // a write into the signature space stores nothing; it only raises this
  // sticky flag so software can spot a stray store. set beats clear.
  assign wrerr_clr = wr_done & stat_hit & avs_byteenable_in[0] & avs_writedata_in[ST_WRERR_BIT];

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wrerr_r <= 1'b0;
    end else if (wr_done & sig_hit) begin
      wrerr_r <= 1'b1;
    end else if (wrerr_clr) begin
      wrerr_r <= 1'b0;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  osc2m_b_copy_a : assert property (
    fll2m_loop_trim_b_out == sig[7:0])
    else $error("2 MHz trim B differs from signature index 0x00");

  osc2m_a_copy_a : assert property (
    fll2m_loop_trim_a_out == sig_byte(IDX_OSC2M_A))
    else $error("2 MHz trim A differs from its signature byte");

  osc32k_copy_a : assert property (
    slow_osc_trim_out == sig_byte(IDX_OSC32K))
    else $error("slow oscillator trim differs from its signature byte");

  osc32m_b_copy_a : assert property (
    fll32m_loop_trim_b_out == sig[31:24])
    else $error("32 MHz trim B differs from signature index 0x03");

  osc32m_a_copy_a : assert property (
    $stable(fll32m_loop_trim_a_out) && fll32m_loop_trim_a_out == sig_byte(IDX_OSC32M_A))
    else $error("32 MHz trim A changed or differs after reset");

  sig_readback_a : assert property (
    (avs_read_in && avs_waitrequest_out && sig_hit)
      ##1 (avs_read_in && !avs_waitrequest_out)
      |-> avs_readdata_out == {24'h00_0000, $past(rom_byte)})
    else $error("signature read returned a value other than the fuse byte");

  sig_write_flag_a : assert property (
    (wr_done && sig_hit) |=> wrerr_r)
    else $error("write to signature space did not raise the write flag");

  lot_bytes_a : assert property (
    serial_number_out[7:0] == sig_byte(IDX_LOT_0)
      && serial_number_out[47:40] == sig[(int'(IDX_LOT_0) + 5)*8 +: 8])
    else $error("lot identifier bytes out of place");

  serial_wafer_a : assert property (
    serial_number_out[55:48] == sig_byte(IDX_WAFER))
    else $error("wafer index missing from serial number");

  wafer_y_high_a : assert property (
    serial_number_out[87:80] == sig[8*21 +: 8])
    else $error("wafer Y byte 1 not taken from index 0x15");

  temp_nibble_a : assert property (
    sig[8*47+4 +: 4] == 4'h0 && temp_ref_out[11:8] == sig[8*47 +: 4])
    else $error("temperature high byte layout broken");

  temp_ref_a : assert property (
    temp_ref_out[7:0] == sig_byte(IDX_TEMP_LOW))
    else $error("temperature low byte differs from reference");

  conv_not_copied_a : assert property (
    fll2m_loop_trim_b_out == sig[7:0] || sig[7:0] == sig_byte(IDX_CONV_A_LO))
    else $error("a converter byte reached an oscillator trim output");

  trim_ready_a : assert property (
    trim_loaded_out && fll32m_loop_trim_b_out == sig[31:24])
    else $error("trim copy not complete at reset release");

  wait_one_a : assert property (
    (req && avs_waitrequest_out) |=> (req |-> !avs_waitrequest_out))
    else $error("slave held waitrequest for more than one cycle");

  // ****************************************
  // checks: bus, status flag, held outputs, serial field layout, unpopulated fuse bytes
  // ****************************************
  // terms are taken from the bus pins where possible, so a slip in the
  // internal strobes shows up here rather than being mirrored

  first_wait_a : assert property (
    (req && !$past(req))
      |-> avs_waitrequest_out)
    else $error("first cycle of a request did not wait");

  status_read_a : assert property (
    (avs_read_in && avs_waitrequest_out && stat_hit) ##1 (avs_read_in && !avs_waitrequest_out)
      |-> avs_readdata_out == {30'h0000_0000, $past(wrerr_r), $past(loaded_r)})
    else $error("status read returned wrong flags");

  hole_read_zero_a : assert property (
    (avs_read_in && avs_waitrequest_out && !stat_hit && !(sig_hit && SIG_MAP[idx]))
      |=> avs_readdata_out == 32'h0000_0000)
    else $error("read of an unpopulated index returned nonzero data");

  readdata_upper_a : assert property (
    avs_readdata_out[31:8] == 24'h00_0000)
    else $error("read data carries bits above the signature byte");

  wrerr_clear_a : assert property (
    (avs_write_in && !avs_waitrequest_out && stat_hit && avs_byteenable_in[0]
      && avs_writedata_in[ST_WRERR_BIT]) |=> !wrerr_r)
    else $error("status write did not clear the write flag");

  wrerr_keep_a : assert property (
    (wrerr_r && !(avs_write_in && !avs_waitrequest_out && stat_hit))
      |=> wrerr_r)
    else $error("write flag dropped without a clearing write");

  wrerr_quiet_a : assert property (
    (!wrerr_r && !(avs_write_in && !avs_waitrequest_out && sig_hit))
      |=> !wrerr_r)
    else $error("write flag rose without a signature write");

  trims_stable_a : assert property (
    !$past(rst_in)
      |-> $stable(fll2m_loop_trim_b_out) && $stable(fll2m_loop_trim_a_out) && $stable(slow_osc_trim_out))
    else $error("oscillator trim changed outside reset");

  serial_stable_a : assert property (
    !$past(rst_in)
      |-> $stable(serial_number_out) && $stable(temp_ref_out))
    else $error("serial number or temperature reference changed outside reset");

  lot_mid_a : assert property (
    serial_number_out[39:8] == sig[(int'(IDX_LOT_0) + 1)*8 +: 32])
    else $error("lot identifier bytes 1 to 4 out of place");

  wafer_x_a : assert property (
    serial_number_out[71:56] == {sig_byte(IDX_X_HIGH), sig_byte(IDX_X_LOW)})
    else $error("wafer X bytes out of place");

  wafer_y_low_a : assert property (
    serial_number_out[79:72] == sig_byte(IDX_Y_LOW))
    else $error("wafer Y byte 0 out of place");

  hole_byte_zero_a : assert property (
    (sig_hit && !SIG_MAP[idx])
      |-> rom_byte == 8'h00)
    else $error("unpopulated signature index shows a nonzero byte");

  conv_readable_a : assert property (
    (avs_read_in && avs_waitrequest_out && idx == IDX_CONV_A_LO)
      |=> avs_readdata_out == {24'h00_0000, sig_byte(IDX_CONV_A_LO)})
    else $error("converter trim byte not readable for software copy");

endmodule : fsr_signature_row
`default_nettype wire

// file: testbench/fsr_signature_row_tb_top.sv
// bench for the factory signature row: trim copy, serial, temperature, bus access
// assumes the design carries its own assertions; the bench drives the bus itself
`timescale 1ns/1ns
`default_nettype none
module fsr_signature_row_tb_top
  import fsr_pkg::*;
;
  // ****************************************
  // fuse image and expected bytes
  // ****************************************
  function automatic logic [7:0] fb(input int i);
    return 8'(i * 37 + 91);
  endfunction : fb
  function automatic logic [8*SIG_DEPTH-1:0] mk_img();
    logic [8*SIG_DEPTH-1:0] r;
    for (int i = 0; i < SIG_DEPTH; i++) r[8*i+:8] = fb(i);
    return r;
  endfunction : mk_img
  // holes and the space past the row read zero
  function automatic logic [7:0] exp_byte(input int i);
    if (i >= SIG_DEPTH || !SIG_MAP[i]) return 8'h00;
    if (i == int'(IDX_TEMP_HIGH)) return fb(i) & TEMP_HIGH_MASK;
    return fb(i);
  endfunction : exp_byte
  localparam logic [8*SIG_DEPTH-1:0] IMG = mk_img();

  logic                clk_in, rst_in, avs_read_in, avs_write_in;
  logic [ADDR_W-1:0]   avs_address_in;
  logic [31:0]         avs_writedata_in, avs_readdata_out;
  logic [3:0]          avs_byteenable_in;
  logic                avs_waitrequest_out, trim_loaded_out;
  logic [7:0]          t2b, t2a, t32k, t32b, t32a;
  logic [SERIAL_W-1:0] serial_number_out;
  logic [TEMP_W-1:0]   temp_ref_out;
  int                  err_count, checked, cycles;

  fsr_signature_row #(.FACTORY_IMAGE(IMG)) i_dut (
    .clk_in(clk_in), .rst_in(rst_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .fll2m_loop_trim_b_out(t2b),
    .fll2m_loop_trim_a_out(t2a), .slow_osc_trim_out(t32k), .fll32m_loop_trim_b_out(t32b),
    .fll32m_loop_trim_a_out(t32a), .serial_number_out(serial_number_out),
    .temp_ref_out(temp_ref_out), .trim_loaded_out(trim_loaded_out));

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // ****************************************
  // reporting
  // ****************************************
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string name, input logic [87:0] exp, input logic [87:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // whole run needs well under a thousand cycles
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      report_and_stop();
    end
  end

  // ****************************************
  // bus master: hold until waitrequest low, take data in that cycle
  // ****************************************
  task automatic bus(input logic wr, input int idx, input logic [31:0] wd, input logic [3:0] be,
                     output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_in);
    avs_address_in    <= {6'(idx), 2'b00};
    avs_writedata_in  <= wd;
    avs_byteenable_in <= be;
    avs_write_in      <= wr;
    avs_read_in       <= !wr;
    // answer taken at the rising edge where waitrequest is low; only the
    // bench timeout ends a wait that never finishes
    do begin
      @(posedge clk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0);
    chk("wait states", 88'd1, 88'(n - 1));
    rd = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in  <= 1'b0;
  endtask : bus

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_outputs();
    logic [87:0] ser;
    logic [7:0]  th;
    th = fb(47);
    for (int k = 0; k < LOT_BYTES; k++) ser[8*k+:8] = fb(8 + k);
    ser[87:48] = {fb(21), fb(20), fb(19), fb(18), fb(16)};
    @(negedge clk_in);
    chk("trim 2m b", fb(0), t2b);
    chk("trim 2m a", fb(1), t2a);
    chk("trim 32k", fb(2), t32k);
    chk("trim 32m b", fb(3), t32b);
    chk("trim 32m a", fb(4), t32a);
    chk("trim loaded", 88'h1, trim_loaded_out);
    chk("serial", ser, serial_number_out);
    chk("temp ref", {th[3:0], fb(46)}, temp_ref_out);
  endtask : t_outputs

  task automatic t_read_all();
    logic [31:0] rd;
    for (int i = 0; i < 64; i++) begin
      if (i == int'(IDX_STATUS)) continue;
      bus(1'b0, i, 32'h0, 4'h0, rd);
      chk($sformatf("index %0d", i), {24'h0, exp_byte(i)}, rd);
    end
  endtask : t_read_all

  task automatic t_write();
    logic [31:0] rd;
    bus(1'b1, 0, 32'hFFFF_FFFF, 4'hF, rd);
    bus(1'b1, 21, 32'h0, 4'hF, rd);
    bus(1'b0, 0, 32'h0, 4'h0, rd);
    chk("index 0 after write", {24'h0, fb(0)}, rd);
    bus(1'b0, 21, 32'h0, 4'h0, rd);
    chk("index 21 after write", {24'h0, fb(21)}, rd);
    chk("trim after write", fb(0), t2b);
    bus(1'b0, 48, 32'h0, 4'h0, rd);
    chk("status flagged", 88'h3, rd);
    // wrong lane must not clear the flag
    bus(1'b1, 48, 32'h2, 4'h2, rd);
    bus(1'b0, 48, 32'h0, 4'h0, rd);
    chk("status wrong lane", 88'h3, rd);
    bus(1'b1, 48, 32'h2, 4'h1, rd);
    bus(1'b0, 48, 32'h0, 4'h0, rd);
    chk("status cleared", 88'h1, rd);
  endtask : t_write

  task automatic t_rereset();
    logic [31:0] rd;
    bus(1'b1, 4, 32'h0, 4'hF, rd);
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    t_outputs();
    bus(1'b0, 48, 32'h0, 4'h0, rd);
    chk("status after reset", 88'h1, rd);
  endtask : t_rereset

  initial begin
    err_count         = 0;
    checked           = 0;
    cycles            = 0;
    rst_in            = 1'b1;
    avs_read_in       = 1'b0;
    avs_write_in      = 1'b0;
    avs_address_in    = 8'h00;
    avs_writedata_in  = 32'h0;
    avs_byteenable_in = 4'h0;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    t_outputs();
    t_read_all();
    t_write();
    t_rereset();
    report_and_stop();
  end
endmodule : fsr_signature_row_tb_top
`default_nettype wire
